//--- src/ctda_cfg.svh
// Constants for the cache tag diagnostic access block
`ifndef CTDA_CFG_SVH
`define CTDA_CFG_SVH
// Transfer codes seen while the test pin is asserted
`define CTDA_TC_RW        4'h1
`define CTDA_TC_INV       4'h2
// Processor address fields in diagnostic mode
`define CTDA_SEL_BIT      3
`define CTDA_BANK_BIT     4
`define CTDA_MEMORY_SIDE_TAG_ARRAY_HI      31
`define CTDA_MEMORY_SIDE_TAG_ARRAY_LO      18
`define CTDA_MIDX_HI      17
`define CTDA_MIDX_LO      5
`define CTDA_PROCESSOR_SIDE_TAG_ARRAY_HI      19
`define CTDA_PROCESSOR_SIDE_TAG_ARRAY_LO      12
`define CTDA_PSET_HI      11
`define CTDA_PSET_LO      5
`define CTDA_PINV_HI      31
`define CTDA_PINV_LO      20
`define CTDA_PLOW_HI      11
`define CTDA_PLOW_LO      1
`define CTDA_MINV_LO      3
`define CTDA_ARR_HI       11
`define CTDA_ARR_DW_LO    3
`define CTDA_STAT_HI      2
// Tag array shapes
`define CTDA_MEMORY_SIDE_TAG_ARRAY_W       17
`define CTDA_MIDX_W       14
`define CTDA_MEMORY_SIDE_TAG_ARRAY_DEPTH   16384
`define CTDA_PROCESSOR_SIDE_TAG_ARRAY_W       9
`define CTDA_PIDX_W       8
`define CTDA_PROCESSOR_SIDE_TAG_ARRAY_DEPTH   256
// Register map, byte addresses
`define CTDA_REG_CTRL     12'h000
`define CTDA_REG_STAT     12'h004
`define CTDA_REG_ERRCNT   12'h008
`define CTDA_REG_LASTTAG  12'h00C
`define CTDA_CTRL_RST     1'h1
`define CTDA_CNT_W        16
`endif

//--- src/ctda_pkg.sv
// Types for the cache tag diagnostic access block
package ctda_pkg;
  typedef enum logic [1:0] {KIND_RW, KIND_INV, KIND_BYP} ctda_kind_type;
  typedef enum logic [1:0] {ST_IDLE, ST_TAG, ST_RESP, ST_SYS} ctda_state_type;
  // Processor request: size 0 byte, 1 half, 2 word, 3 double
  typedef struct packed {
    logic [31:0] addr;
    logic        rd;
    logic [3:0]  tc;
    logic [1:0]  size;
    logic [63:0] wdata;
  } ctda_preq_type;
  typedef struct packed {
    logic [31:0] addr;
    logic        rd;
    logic        global;
    logic        inval;
    logic [63:0] wdata;
  } ctda_sreq_type;
  typedef struct packed {
    logic        cs;
    logic        we;
    logic [11:0] addr;
    logic [7:0]  be;
    logic [63:0] wdata;
  } ctda_arr_type;
endpackage : ctda_pkg

//--- src/ctda_top.sv
// Diagnostic-mode tag, bypass and invalidate logic of a secondary cache controller
//
// Contract
// - Bypass accesses never read or write tags
// - No snooping while test pin asserted
// - Address bit 3 picks tag array
// - Memory tag index bits 17-5, bank bit 4
// - Processor tag set bits 11-5, line bit 4
// - Diagnostic mapping ignores reset configuration
// - Every diagnostic transfer is single beat
// - Memory tag write stores 31-18 and status
// - Memory tag read compares, error on mismatch
// - Processor tag write stores 19-12, inclusion
// - Processor tag read compares, error on mismatch
// - Bus data written into cache data array
// - Data array addressed by bits 11-0
// - Tag work concurrent with array transfer
// - Bypass data moves through system interface
// - Touch/allocate load starts non-global invalidate
// - Memory-side invalidate address from tag, address, status
// - Processor-side invalidate address from address, tag, inclusion
// - Transfer code decodes read/write, invalidate, bypass
`timescale 1ns/1ps
`default_nettype none
`include "ctda_cfg.svh"
module ctda_top
(
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  reset_i,
  // APB register port
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [11:0]           paddr_i,
  input  wire logic [31:0]           pwdata_i,
  output var  logic [31:0]           prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  // Diagnostic pin
  input  wire logic                  test_access_mode_pin_i,
  // Processor bus
  input  wire logic                  p_start_i,
  input  wire ctda_pkg::ctda_preq_type p_req_i,
  output logic                       processor_transfer_ack_o,
  output logic                       processor_transfer_error_ack_o,
  output var  logic [63:0]           p_rdata_o,
  // External cache data array
  output var  ctda_pkg::ctda_arr_type arr_o,
  // System bus master side
  output logic                       sys_req_o,
  output var  ctda_pkg::ctda_sreq_type sys_o,
  input  wire logic                  sys_done_i,
  input  wire logic [63:0]           sys_rdata_i,
  // System bus snoop side
  input  wire logic                  snoop_valid_i,
  output logic                       snoop_lookup_o
);

  ctda_pkg::ctda_state_type state_r;
  ctda_pkg::ctda_kind_type  kind_r;
  ctda_pkg::ctda_preq_type  req_r;
  logic                     sel_m_r;
  logic [`CTDA_MEMORY_SIDE_TAG_ARRAY_W-1:0]  memory_side_tag_array_mem [`CTDA_MEMORY_SIDE_TAG_ARRAY_DEPTH];
  logic [`CTDA_PROCESSOR_SIDE_TAG_ARRAY_W-1:0]  processor_side_tag_array_mem [`CTDA_PROCESSOR_SIDE_TAG_ARRAY_DEPTH];
  logic [`CTDA_MEMORY_SIDE_TAG_ARRAY_W-1:0]  memory_side_tag_array_rd_r;
  logic [`CTDA_PROCESSOR_SIDE_TAG_ARRAY_W-1:0]  processor_side_tag_array_rd_r;
  logic [`CTDA_MIDX_W-1:0]  midx;
  logic [`CTDA_PIDX_W-1:0]  pidx;
  logic [`CTDA_MEMORY_SIDE_TAG_ARRAY_W-1:0]  mexp;
  logic [`CTDA_PROCESSOR_SIDE_TAG_ARRAY_W-1:0]  pexp;
  logic                     mismatch;
  logic                     tag_rd_en;
  logic                     tag_we;
  logic                     take;
  logic                     ctrl_snoop_en_r;
  logic [`CTDA_CNT_W-1:0]   errcnt_r;
  logic                     last_mis_r;
  logic [31:0]              lasttag_r;
  ctda_pkg::ctda_kind_type  kind_nxt;

  // Request accepted only in diagnostic mode; normal traffic lives elsewhere
  assign take = p_start_i && test_access_mode_pin_i && (state_r == ctda_pkg::ST_IDLE);

  always_comb
  begin
    case (p_req_i.tc)
      `CTDA_TC_RW:  kind_nxt = ctda_pkg::KIND_RW;
      `CTDA_TC_INV: kind_nxt = ctda_pkg::KIND_INV;
      default:      kind_nxt = ctda_pkg::KIND_BYP;
    endcase
  end

  // Fixed diagnostic field mapping, independent of any cache configuration
  assign midx = {req_r.addr[`CTDA_BANK_BIT], req_r.addr[`CTDA_MIDX_HI:`CTDA_MIDX_LO]};
  assign pidx = {req_r.addr[`CTDA_PSET_HI:`CTDA_PSET_LO], req_r.addr[`CTDA_BANK_BIT]};
  assign mexp = {req_r.addr[`CTDA_MEMORY_SIDE_TAG_ARRAY_HI:`CTDA_MEMORY_SIDE_TAG_ARRAY_LO], req_r.addr[`CTDA_STAT_HI:0]};
  assign pexp = {req_r.addr[`CTDA_PROCESSOR_SIDE_TAG_ARRAY_HI:`CTDA_PROCESSOR_SIDE_TAG_ARRAY_LO], req_r.addr[0]};

  // Bypass never enters the tag state, so tags stay untouched
  assign tag_rd_en = (state_r == ctda_pkg::ST_TAG) && (kind_r != ctda_pkg::KIND_BYP);
  assign tag_we    = tag_rd_en && (kind_r == ctda_pkg::KIND_RW) && !req_r.rd;
  assign mismatch  = sel_m_r ? (memory_side_tag_array_rd_r != mexp) : (processor_side_tag_array_rd_r != pexp);

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state_r <= ctda_pkg::ST_IDLE;
    end
    else
    begin
      case (state_r)
        ctda_pkg::ST_IDLE:
          if (take)
            state_r <= (kind_nxt == ctda_pkg::KIND_BYP) ? ctda_pkg::ST_SYS : ctda_pkg::ST_TAG;
        ctda_pkg::ST_TAG:
          state_r <= (kind_r == ctda_pkg::KIND_INV) ? ctda_pkg::ST_SYS : ctda_pkg::ST_RESP;
        ctda_pkg::ST_RESP:
          state_r <= ctda_pkg::ST_IDLE;
        ctda_pkg::ST_SYS:
          if (sys_done_i)
            state_r <= ctda_pkg::ST_IDLE;
        default:
          state_r <= ctda_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      req_r   <= '0;
      kind_r  <= ctda_pkg::KIND_BYP;
      sel_m_r <= 1'h0;
    end
    else if (take)
    begin
      req_r   <= p_req_i;
      kind_r  <= kind_nxt;
      sel_m_r <= p_req_i.addr[`CTDA_SEL_BIT];
    end
  end

  // Tag arrays: one port each, a write also loads the read register from the same entry
  always_ff @(posedge clk_i)
  begin
    if (tag_rd_en && sel_m_r)
    begin
      if (tag_we)
        memory_side_tag_array_mem[midx] <= mexp;
      memory_side_tag_array_rd_r <= memory_side_tag_array_mem[midx];
    end
    if (tag_rd_en && !sel_m_r)
    begin
      if (tag_we)
        processor_side_tag_array_mem[pidx] <= pexp;
      processor_side_tag_array_rd_r <= processor_side_tag_array_mem[pidx];
    end
  end

  function automatic logic [7:0] ctda_be(input logic [1:0] size, input logic [2:0] lo);
    logic [7:0] m;
    m = 8'hFF;
    case (size)
      2'h0:    m = 8'h01 << lo;
      2'h1:    m = 8'h03 << {lo[2:1], 1'h0};
      2'h2:    m = 8'h0F << {lo[2], 2'h0};
      default: m = 8'hFF;
    endcase
    return m;
  endfunction : ctda_be

  // Array access shares the tag cycle, so tag checks add no latency
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      arr_o <= '0;
    else if (take && kind_nxt == ctda_pkg::KIND_RW)
    begin
      arr_o.cs    <= 1'h1;
      arr_o.we    <= !p_req_i.rd;
      arr_o.addr  <= p_req_i.addr[`CTDA_ARR_HI:0];
      arr_o.be    <= ctda_be(p_req_i.size, p_req_i.addr[`CTDA_ARR_DW_LO-1:0]);
      arr_o.wdata <= p_req_i.wdata;
    end
    else
    begin
      arr_o.cs <= 1'h0;
      arr_o.we <= 1'h0;
    end
  end

  // System request contents: bypass set up on acceptance, invalidate while the tag is read
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      sys_o <= '0;
    else if (take && kind_nxt == ctda_pkg::KIND_BYP)
    begin
      sys_o.addr   <= p_req_i.addr;
      sys_o.rd     <= p_req_i.rd;
      sys_o.global <= 1'h1;
      sys_o.inval  <= 1'h0;
      sys_o.wdata  <= p_req_i.wdata;
    end
    else if (state_r == ctda_pkg::ST_TAG && kind_r == ctda_pkg::KIND_INV)
    begin
      sys_o.rd     <= 1'h0;
      sys_o.global <= 1'h0;
      sys_o.inval  <= 1'h1;
      sys_o.wdata  <= '0;
      if (sel_m_r)
        sys_o.addr <= {memory_side_tag_array_mem[midx][`CTDA_MEMORY_SIDE_TAG_ARRAY_W-1:`CTDA_STAT_HI+1],
                       req_r.addr[`CTDA_MIDX_HI:`CTDA_MINV_LO],
                       memory_side_tag_array_mem[midx][0], memory_side_tag_array_mem[midx][1], memory_side_tag_array_mem[midx][2]};
      else
        sys_o.addr <= {req_r.addr[`CTDA_PINV_HI:`CTDA_PINV_LO],
                       processor_side_tag_array_mem[pidx][`CTDA_PROCESSOR_SIDE_TAG_ARRAY_W-1:1],
                       req_r.addr[`CTDA_PLOW_HI:`CTDA_PLOW_LO],
                       processor_side_tag_array_mem[pidx][0]};
    end
  end

  assign sys_req_o = (state_r == ctda_pkg::ST_SYS);

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      p_rdata_o <= '0;
    else if (sys_req_o && sys_done_i && sys_o.rd)
      p_rdata_o <= sys_rdata_i;
  end

  // Compare only on tag reads; writes and invalidates always end cleanly
  assign processor_transfer_error_ack_o = (state_r == ctda_pkg::ST_RESP) && req_r.rd && mismatch;
  assign processor_transfer_ack_o = ((state_r == ctda_pkg::ST_RESP) && !(req_r.rd && mismatch))
                                    || (sys_req_o && sys_done_i);

  // Snoops are dropped outright while the pin is asserted
  assign snoop_lookup_o = snoop_valid_i && !test_access_mode_pin_i && ctrl_snoop_en_r;

  // APB slave: zero wait states, unmapped addresses answer with an error
  logic apb_acc;
  logic apb_hit;
  assign apb_acc   = psel_i && penable_i;
  assign apb_hit   = (paddr_i == `CTDA_REG_CTRL) || (paddr_i == `CTDA_REG_STAT)
                     || (paddr_i == `CTDA_REG_ERRCNT) || (paddr_i == `CTDA_REG_LASTTAG);
  assign pready_o  = 1'h1;
  assign pslverr_o = apb_acc && !apb_hit;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      ctrl_snoop_en_r <= `CTDA_CTRL_RST;
    else if (apb_acc && pwrite_i && paddr_i == `CTDA_REG_CTRL)
      ctrl_snoop_en_r <= pwdata_i[0];
  end

  // Mismatch counter; the increment wins over a software clear in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      errcnt_r   <= '0;
      last_mis_r <= 1'h0;
      lasttag_r  <= '0;
    end
    else
    begin
      if (processor_transfer_error_ack_o)
        errcnt_r <= errcnt_r + `CTDA_CNT_W'(1);
      else if (apb_acc && pwrite_i && paddr_i == `CTDA_REG_ERRCNT)
        errcnt_r <= '0;
      if (state_r == ctda_pkg::ST_RESP && req_r.rd)
      begin
        last_mis_r <= mismatch;
        lasttag_r  <= sel_m_r ? 32'(memory_side_tag_array_rd_r) : 32'(processor_side_tag_array_rd_r);
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      prdata_o <= '0;
    else if (psel_i && !penable_i && !pwrite_i)
    begin
      case (paddr_i)
        `CTDA_REG_CTRL:    prdata_o <= 32'(ctrl_snoop_en_r);
        `CTDA_REG_STAT:    prdata_o <= 32'({last_mis_r, kind_r, state_r, test_access_mode_pin_i});
        `CTDA_REG_ERRCNT:  prdata_o <= 32'(errcnt_r);
        `CTDA_REG_LASTTAG: prdata_o <= lasttag_r;
        default:           prdata_o <= '0;
      endcase
    end
  end

  // are kept by software and the system around this block

  a_ack_exclusive: assert property (@(posedge clk_i) disable iff (reset_i)
    !(processor_transfer_ack_o && processor_transfer_error_ack_o))
    else $error("ack and error ack together");
  a_snoop_blocked: assert property (@(posedge clk_i) disable iff (reset_i)
    test_access_mode_pin_i |-> !snoop_lookup_o)
    else $error("snoop while test pin asserted");
  a_bypass_no_tag: assert property (@(posedge clk_i) disable iff (reset_i)
    (take && kind_nxt == ctda_pkg::KIND_BYP) |=> !tag_rd_en throughout (sys_req_o [*1]))
    else $error("bypass touched tags");
  a_bypass_to_sys: assert property (@(posedge clk_i) disable iff (reset_i)
    (take && kind_nxt == ctda_pkg::KIND_BYP) |=> sys_req_o && sys_o.global && sys_o.addr == $past(p_req_i.addr))
    else $error("bypass not sent to system bus");
  a_inv_nonglobal: assert property (@(posedge clk_i) disable iff (reset_i)
    (take && kind_nxt == ctda_pkg::KIND_INV) |-> ##2 sys_req_o && sys_o.inval && !sys_o.global)
    else $error("invalidate not issued non-global");
  a_inv_mside_addr: assert property (@(posedge clk_i) disable iff (reset_i)
    (sys_req_o && sys_o.inval && sel_m_r) |-> sys_o.addr[17:3] == req_r.addr[17:3])
    else $error("memory-side invalidate address wrong");
  a_inv_pside_addr: assert property (@(posedge clk_i) disable iff (reset_i)
    (sys_req_o && sys_o.inval && !sel_m_r) |-> sys_o.addr[31:20] == req_r.addr[31:20]
      && sys_o.addr[11:1] == req_r.addr[11:1])
    else $error("processor-side invalidate address wrong");
  a_single_beat: assert property (@(posedge clk_i) disable iff (reset_i)
    processor_transfer_ack_o |=> !processor_transfer_ack_o)
    else $error("more than one beat acknowledged");
  a_rw_timing: assert property (@(posedge clk_i) disable iff (reset_i)
    (take && kind_nxt == ctda_pkg::KIND_RW) |=> arr_o.cs && tag_rd_en ##1
      (processor_transfer_ack_o || processor_transfer_error_ack_o))
    else $error("tag and array access not concurrent");
  a_write_then_match: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_r == ctda_pkg::ST_RESP && !req_r.rd) |-> processor_transfer_ack_o)
    else $error("write not acknowledged");
  a_byp_no_tag_use: assert property (@(posedge clk_i) disable iff (reset_i)
    (kind_r == ctda_pkg::KIND_BYP) |-> !tag_rd_en && !tag_we)
    else $error("bypass kind used the tags");
  a_idle_quiet: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_r == ctda_pkg::ST_IDLE) |-> !processor_transfer_ack_o && !processor_transfer_error_ack_o && !sys_req_o)
    else $error("answer while idle");
  a_decode_kind: assert property (@(posedge clk_i) disable iff (reset_i)
    take |=> kind_r == (($past(p_req_i.tc) == `CTDA_TC_RW) ? ctda_pkg::KIND_RW
      : (($past(p_req_i.tc) == `CTDA_TC_INV) ? ctda_pkg::KIND_INV : ctda_pkg::KIND_BYP)))
    else $error("transfer code decoded wrongly");
  a_sel_from_bit: assert property (@(posedge clk_i) disable iff (reset_i)
    take |=> sel_m_r == $past(p_req_i.addr[`CTDA_SEL_BIT]))
    else $error("tag array select wrong");
  a_arr_low_addr: assert property (@(posedge clk_i) disable iff (reset_i)
    (take && kind_nxt == ctda_pkg::KIND_RW) |=> arr_o.addr == $past(p_req_i.addr[`CTDA_ARR_HI:0]))
    else $error("array address wrong");
  a_arr_write_data: assert property (@(posedge clk_i) disable iff (reset_i)
    (take && kind_nxt == ctda_pkg::KIND_RW && !p_req_i.rd) |=> arr_o.we && arr_o.wdata == $past(p_req_i.wdata))
    else $error("array write data wrong");
  a_memory_side_tag_array_stored: assert property (@(posedge clk_i) disable iff (reset_i)
    (tag_we && sel_m_r) |=> memory_side_tag_array_mem[midx] == mexp)
    else $error("memory-side tag not stored");
  a_processor_side_tag_array_stored: assert property (@(posedge clk_i) disable iff (reset_i)
    (tag_we && !sel_m_r) |=> processor_side_tag_array_mem[pidx] == pexp)
    else $error("processor-side tag not stored");
  a_memory_side_tag_array_cmp_err: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_r == ctda_pkg::ST_RESP && req_r.rd && sel_m_r) |-> processor_transfer_error_ack_o == (memory_side_tag_array_rd_r != mexp))
    else $error("memory-side compare result wrong");
  a_processor_side_tag_array_cmp_err: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_r == ctda_pkg::ST_RESP && req_r.rd && !sel_m_r) |-> processor_transfer_error_ack_o == (processor_side_tag_array_rd_r != pexp))
    else $error("processor-side compare result wrong");
  a_inv_memory_side_tag_array_bits: assert property (@(posedge clk_i) disable iff (reset_i)
    (sys_req_o && sys_o.inval && sel_m_r)
      |-> sys_o.addr[`CTDA_MEMORY_SIDE_TAG_ARRAY_HI:`CTDA_MEMORY_SIDE_TAG_ARRAY_LO] == memory_side_tag_array_mem[midx][`CTDA_MEMORY_SIDE_TAG_ARRAY_W-1:`CTDA_STAT_HI+1]
      && sys_o.addr[`CTDA_STAT_HI:0] == {memory_side_tag_array_mem[midx][0], memory_side_tag_array_mem[midx][1], memory_side_tag_array_mem[midx][2]})
    else $error("memory-side invalidate tag bits wrong");
  a_inv_processor_side_tag_array_bits: assert property (@(posedge clk_i) disable iff (reset_i)
    (sys_req_o && sys_o.inval && !sel_m_r)
      |-> sys_o.addr[`CTDA_PROCESSOR_SIDE_TAG_ARRAY_HI:`CTDA_PROCESSOR_SIDE_TAG_ARRAY_LO] == processor_side_tag_array_mem[pidx][`CTDA_PROCESSOR_SIDE_TAG_ARRAY_W-1:1]
      && sys_o.addr[0] == processor_side_tag_array_mem[pidx][0])
    else $error("processor-side invalidate tag bits wrong");
  a_sys_req_hold: assert property (@(posedge clk_i) disable iff (reset_i)
    (sys_req_o && !sys_done_i) |=> sys_req_o && $stable(sys_o))
    else $error("system request dropped or changed");

endmodule : ctda_top
`default_nettype wire

//--- verif/ctda_sys_model.sv
// System bus responder model for the diagnostic bench
`timescale 1ns/1ps
`default_nettype none
module ctda_sys_model
(
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    reset_i,
  // Request from the block
  input  wire logic                    sys_req_i,
  input  wire ctda_pkg::ctda_sreq_type sys_i,
  input  wire logic [3:0]              delay_i,
  // Answer
  output logic                         sys_done_o,
  output logic [63:0]                  sys_rdata_o
);
  logic [3:0] cnt_r;
  // One request at a time; never starts global traffic itself
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      cnt_r       <= 4'h0;
      sys_done_o  <= 1'h0;
      sys_rdata_o <= 64'h0;
    end
    else if (sys_req_i && !sys_done_o && cnt_r >= delay_i)
    begin
      sys_done_o  <= 1'h1;
      sys_rdata_o <= {sys_i.addr, ~sys_i.addr};
      cnt_r       <= 4'h0;
    end
    else
    begin
      sys_done_o  <= 1'h0;
      // Stale data flips so it never passes for an answer
      sys_rdata_o <= ~sys_rdata_o;
      cnt_r       <= (sys_req_i && !sys_done_o) ? cnt_r + 4'h1 : 4'h0;
    end
  end
endmodule : ctda_sys_model
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for the diagnostic access block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {logic err; logic sy; logic rc; logic [31:0] sa; logic gl; logic [63:0] rd;} ctda_exp_type;
  logic clk_i, reset_i, psel, penable, pwrite, pin, p_start, snoop_valid, pready, pslverr;
  logic ack, eack, sys_req, sys_done, lookup, pend;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed, a, b;
  logic [63:0] p_rdata, sys_rdata, pval;
  logic [3:0] dly;
  ctda_pkg::ctda_preq_type p_req;
  ctda_pkg::ctda_arr_type arr;
  ctda_pkg::ctda_sreq_type sys;
  ctda_exp_type q[$];
  ctda_exp_type e;
  int err_total, check_count;
  ctda_top dut (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .test_access_mode_pin_i(pin), .p_start_i(p_start), .p_req_i(p_req), .processor_transfer_ack_o(ack),
    .processor_transfer_error_ack_o(eack), .p_rdata_o(p_rdata), .arr_o(arr), .sys_req_o(sys_req),
    .sys_o(sys), .sys_done_i(sys_done), .sys_rdata_i(sys_rdata), .snoop_valid_i(snoop_valid),
    .snoop_lookup_o(lookup));
  ctda_sys_model partner (.clk_i(clk_i), .reset_i(reset_i), .sys_req_i(sys_req), .sys_i(sys),
    .delay_i(dly), .sys_done_o(sys_done), .sys_rdata_o(sys_rdata));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'h1)
    begin
      err_total++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d, input logic [31:0] x,
                     input logic xe);
    @(posedge clk_i);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge clk_i);
    penable <= 1'h1;
    do
    begin
      @(posedge clk_i);
    end
    while (pready !== 1'h1);
    chk(pslverr === xe && (w || prdata === x), "register access");
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  // Expectation goes on the queue before the request leaves
  task automatic xfer(input logic [31:0] ad, input logic r, input logic [3:0] tc, input logic er,
                      input logic sy, input logic [31:0] sa, input logic gl);
    int n;
    int c;
    logic [63:0] wd;
    logic [7:0] be;
    wd = {seed, ~seed};
    case (seed[1:0])
      2'h0:    be = 8'h01 << ad[2:0];
      2'h1:    be = 8'h03 << {ad[2:1], 1'h0};
      2'h2:    be = 8'h0F << {ad[2], 2'h0};
      default: be = 8'hFF;
    endcase
    q.push_back('{er, sy, sy & r & gl, sa, gl, {ad, ~ad}});
    @(posedge clk_i);
    p_start <= 1'h1;
    p_req   <= '{ad, r, tc, seed[1:0], wd};
    dly     <= {1'h0, seed[6:4]};
    seed = xs(seed);
    @(posedge clk_i);
    p_start <= 1'h0;
    n = 0;
    c = 0;
    do
    begin
      @(negedge clk_i);
      n++;
      if (arr.cs === 1'h1)
      begin
        c++;
        chk(arr.addr === ad[11:0] && arr.we === !r && arr.be === be && (r || arr.wdata === wd), "array access");
      end
    end
    while (ack !== 1'h1 && eack !== 1'h1 && n < 40);
    chk(n < 40, "no answer");
    chk(c == ((tc == 4'h1) ? 1 : 0), "array beats");
  endtask : xfer
  always @(negedge clk_i)
  begin
    if (pend)
      chk(p_rdata === pval, "bypass read data");
    pend = 1'h0;
    if (!reset_i && (ack === 1'h1 || eack === 1'h1))
    begin
      if (q.size() == 0)
        chk(1'h0, "unexpected answer");
      else
      begin
        e = q.pop_front();
        chk(eack === e.err && ack === !e.err, "ack kind");
        if (e.sy)
          chk(sys.addr === e.sa && sys.global === e.gl && sys.inval === !e.gl && sys.rd === e.rc, "system request");
        pend = e.rc;
        pval = e.rd;
      end
    end
  end
  initial
  begin
    clk_i = 1'h0;
    forever #2 clk_i = ~clk_i;
  end
  initial
  begin
    repeat (5000) @(posedge clk_i);
    err_total++;
    $display("BAD %0t watchdog", $time);
    finish_test;
  end
  initial
  begin
    {reset_i, psel, penable, pwrite, pin, p_start, snoop_valid, pend} = 8'h82;
    {paddr, pwdata, p_req, dly} = '0;
    seed = 32'h78D6;
    err_total = 0;
    check_count = 0;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'h0;
    @(negedge clk_i);
    chk(lookup === 1'h1, "snoop idle");
    @(posedge clk_i);
    pin <= 1'h1;
    @(negedge clk_i);
    chk(lookup === 1'h0, "snoop in test");
    $display("test snoop done");
    apb(1'h0, 12'h000, 32'h0, 32'h1, 1'h0);
    apb(1'h0, 12'h010, 32'h0, 32'h0, 1'h1);
    $display("test registers done");
    repeat (4)
    begin
      // Low address bits carry status; alignment faults are off
      a = xs(seed);
      seed = a;
      a[3] = 1'h1;
      xfer(a, 1'h0, 4'h1, 1'h0, 1'h0, 32'h0, 1'h0);
      xfer(a, 1'h1, 4'h1, 1'h0, 1'h0, 32'h0, 1'h0);
      xfer(a ^ 32'h1, 1'h1, 4'h1, 1'h1, 1'h0, 32'h0, 1'h0);
      xfer(a ^ 32'h40000, 1'h1, 4'h1, 1'h1, 1'h0, 32'h0, 1'h0);
      b = {seed[31:18], a[17:3], seed[2:0]};
      xfer(b, 1'h1, 4'h2, 1'h0, 1'h1, {a[31:18], a[17:3], a[0], a[1], a[2]}, 1'h0);
      xfer(a & 32'hFFFFFFF8, 1'h0, 4'h1, 1'h0, 1'h0, 32'h0, 1'h0);
      a = xs(seed);
      seed = a;
      a[3] = 1'h0;
      xfer(a, 1'h0, 4'h1, 1'h0, 1'h0, 32'h0, 1'h0);
      xfer(a, 1'h1, 4'h1, 1'h0, 1'h0, 32'h0, 1'h0);
      xfer(a ^ 32'h1000, 1'h1, 4'h1, 1'h1, 1'h0, 32'h0, 1'h0);
      xfer(a ^ 32'h1, 1'h1, 4'h1, 1'h1, 1'h0, 32'h0, 1'h0);
      b = {seed[31:20], seed[19:12], a[11:1], seed[0]};
      xfer(b, 1'h1, 4'h2, 1'h0, 1'h1, {b[31:20], a[19:12], a[11:1], a[0]}, 1'h0);
      xfer(a & 32'hFFFFFFFE, 1'h0, 4'h1, 1'h0, 1'h0, 32'h0, 1'h0);
    end
    apb(1'h0, 12'h00C, 32'h0, {23'h0, a[19:12], a[0]}, 1'h0);
    $display("test tags done");
    for (int t = 0; t < 16; t++)
      if (t != 1 && t != 2)
      begin
        a = xs(seed);
        seed = a;
        xfer(a, a[0], t[3:0], 1'h0, 1'h1, a, 1'h1);
      end
    apb(1'h0, 12'h004, 32'h0, 32'h31, 1'h0);
    $display("test bypass done");
    apb(1'h0, 12'h008, 32'h0, 32'h10, 1'h0);
    apb(1'h1, 12'h008, 32'h0, 32'h0, 1'h0);
    apb(1'h0, 12'h008, 32'h0, 32'h0, 1'h0);
    $display("test counter done");
    // Pin released only well after the last acknowledge
    repeat (2) @(posedge clk_i);
    pin <= 1'h0;
    repeat (4) @(posedge clk_i);
    finish_test;
  end
endmodule : testbench
`default_nettype wire
